// [vmon_pkg.sv]
package vmon_pkg;

  // Clock and delays.
  localparam int CLK_PERIOD_NS  = 50;
  // Settling delay of a detector after its enable bit rises.
  localparam int SETTLE_NS      = 100000;
  localparam int SETTLE_CYC     = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  // Period of the low-speed on-chip oscillator.
  localparam int OSC_PERIOD_NS  = 8000;
  localparam int OSC_PERIOD_CYC = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int FILT_SAMPLES   = 4;
  localparam int TIMER_W        = 16;

  // Device register addresses.
  localparam logic [7:0] WRITE_PROTECT_ADDR      = 8'h10;
  localparam logic [7:0] SYS_CLOCK_CTRL_ONE_ADDR = 8'h11;
  localparam logic [7:0] LEVEL_STATUS_ADDR       = 8'h12;
  localparam logic [7:0] DETECTOR_ENABLE_ADDR    = 8'h13;
  localparam logic [7:0] MON_ONE_CTRL_ADDR       = 8'h14;
  localparam logic [7:0] MON_TWO_CTRL_ADDR       = 8'h15;

  // Device field positions.
  localparam int MONITOR_WRITE_UNLOCK_BIT = 3;
  localparam int LOWSPEED_OSC_STOP_BIT    = 4;
  localparam int DET_ONE_ENABLE_BIT       = 6;
  localparam int DET_TWO_ENABLE_BIT       = 7;
  localparam int SUPPLY_ABOVE_TWO_BIT     = 3;
  localparam int MON_ENABLE_BIT           = 0;
  localparam int MON_FILTER_OFF_BIT       = 1;
  localparam int MON_CROSS_FLAG_BIT       = 2;
  localparam int MON_FCLK_SEL_LO_BIT      = 4;
  localparam int MON_MODE_BIT             = 6;
  localparam int MON_DIRECTION_BIT        = 7;

  // Shadow values assumed for the device after its reset.
  localparam logic [7:0] DETECTOR_ENABLE_RST    = 8'h00;
  localparam logic [7:0] SYS_CLOCK_CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] MON_CTRL_RST           = 8'h00;

  // Controller command registers.
  localparam logic [3:0] CMD_CFG_OFS    = 4'h0;
  localparam logic [3:0] CMD_CTRL_OFS   = 4'h1;
  localparam logic [3:0] CMD_STATUS_OFS = 4'h2;
  localparam int CTRL_START_BIT       = 0;
  localparam int CTRL_READ_LEVEL_BIT  = 1;
  localparam int CTRL_CLEAR_FLAG_BIT  = 2;
  localparam int CTRL_DISABLE_BIT     = 3;
  localparam int CTRL_READ_FLAG_BIT   = 4;
  localparam int CTRL_CLR_REFUSED_BIT = 7;

  typedef struct packed {
    logic       stop_wake;
    logic [1:0] fclk_sel;
    logic       direction;
    logic       mode;
    logic       use_filter;
    logic       mon_two;
  } cfg_s;

  localparam cfg_s CFG_RST = '0;

  typedef struct packed {
    logic refused;
    logic cross_flag;
    logic two_active;
    logic one_active;
    logic level_valid;
    logic level_above;
    logic done;
    logic busy;
  } status_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } dev_bus_s;

  localparam dev_bus_s DEV_BUS_IDLE = '0;

endpackage

// [wait_timer.sv]
`timescale 1ns/1ps
module wait_timer #(
  parameter int W = vmon_pkg::TIMER_W
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_b,
  // Load and status.
  input  wire logic         start,
  input  wire logic [W-1:0] load,
  output logic              idle
);

  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count <= '0;
    else if (start)
      count <= load;
    else if (count != '0)
      count <= count - W'(1);
  end

  assign idle = (count == '0);

endmodule // wait_timer

// [dev_access.sv]
`timescale 1ns/1ps
module dev_access (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Request from the sequencer.
  input  wire logic               req,
  input  wire logic               we,
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wdata,
  output logic                    done,
  output logic [7:0]              rdata,
  // Device register port.
  output vmon_pkg::dev_bus_s      bus,
  input  wire logic [7:0]         dev_rdata
);

  typedef enum logic [2:0] {A_IDLE, A_UNLOCK, A_WRITE, A_READ, A_CAPTURE}
    acc_e;

  acc_e       st;
  logic [7:0] hold_addr;
  logic [7:0] hold_data;
  logic [7:0] unlock_data;

  always_comb
  begin
    unlock_data = 8'h00;
    unlock_data[vmon_pkg::MONITOR_WRITE_UNLOCK_BIT] = 1'b1;
  end

  // Every write goes out as an unlock write followed at once by the
  // target write, so a stray protect relock can never intervene.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st        <= A_IDLE;
      bus       <= vmon_pkg::DEV_BUS_IDLE;
      done      <= 1'b0;
      rdata     <= 8'h00;
      hold_addr <= 8'h00;
      hold_data <= 8'h00;
    end
    else
    begin
      bus  <= vmon_pkg::DEV_BUS_IDLE;
      done <= 1'b0;
      unique case (st)
        A_IDLE:
          if (req)
          begin
            hold_addr <= addr;
            hold_data <= wdata;
            if (we)
            begin
              bus.addr  <= vmon_pkg::WRITE_PROTECT_ADDR; // [R22]
              bus.wdata <= unlock_data;
              bus.wr    <= 1'b1;
              st        <= A_UNLOCK;
            end
            else
            begin
              bus.addr <= addr;
              bus.rd   <= 1'b1;
              st       <= A_READ;
            end
          end
        A_UNLOCK:
        begin
          bus.addr  <= hold_addr;
          bus.wdata <= hold_data;
          bus.wr    <= 1'b1;
          st        <= A_WRITE;
        end
        A_WRITE:
        begin
          done <= 1'b1;
          st   <= A_IDLE;
        end
        A_READ:
          st <= A_CAPTURE;
        A_CAPTURE:
        begin
          rdata <= dev_rdata;
          done  <= 1'b1;
          st    <= A_IDLE;
        end
      endcase
    end
  end

  sequence unlock_s;
    bus.wr && bus.addr == vmon_pkg::WRITE_PROTECT_ADDR;
  endsequence

  sequence target_s;
    bus.wr && bus.addr != vmon_pkg::WRITE_PROTECT_ADDR ##1 done;
  endsequence

  unlock_first_a: assert property ( // [R22]
    @(posedge clk) disable iff (!rst_b)
    bus.wr && bus.addr != vmon_pkg::WRITE_PROTECT_ADDR
    |-> $past(bus.wr) && $past(bus.addr) == vmon_pkg::WRITE_PROTECT_ADDR)
    else $error("device write without unlock just before");

  unlock_then_target_a: assert property ( // [R22]
    @(posedge clk) disable iff (!rst_b)
    unlock_s |=> target_s)
    else $error("unlock not followed by target write and done");

endmodule // dev_access

// [vmon_host.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Only threshold two has a readable level.
// [R2] Level read only after detector two settled.
// [R3] Stop-wake use of monitor one forces filter off.
// [R4] Stop-wake use of monitor two forces filter off.
// [R5] Enable detector one, wait settle, then configure.
// [R6] Enable detector two, wait settle, then configure.
// [R7] Filtered: write divider and clear filter-off.
// [R8] Unfiltered monitor one: direction and filter-off set.
// [R9] Unfiltered monitor two: chosen direction, filter-off set.
// [R10] Monitor one always written in reset mode; a disable or flag clear before its first setup writes its mode bit as zero.
// [R11] Monitor two mode: zero interrupt, one reset.
// [R12] Monitor two reset mode forces falling direction.
// [R13] Clear monitor one flag before enabling.
// [R14] Clear monitor two flag before enabling.
// [R15] Filter used: start low-speed oscillator before enable.
// [R16] Filter used: wait four sampling clocks first.
// [R17] Enable bit written last of the setup.
// [R18] Divider, filter-off, mode in one write, disabled.
// [R19] Sampling period is oscillator over n, times four.
// [R20] Direction matters only while filter is off.
// [R21] Monitor two flag cleared only by writing zero.
// [R22] Unlock write protection before each monitor write.
// [R23] Settle delay counted as fixed cycles.
module vmon_host #(
  parameter int SETTLE_CYC     = vmon_pkg::SETTLE_CYC,
  parameter int OSC_PERIOD_CYC = vmon_pkg::OSC_PERIOD_CYC
) (
  // Clock and reset.
  input  wire logic               CORE_CLK,
  input  wire logic               RST_B,
  // Command port.
  input  wire logic [3:0]         CMD_ADDR,
  input  wire logic [7:0]         CMD_WDATA,
  input  wire logic               CMD_WR,
  input  wire logic               CMD_RD,
  output logic [7:0]              CMD_RDATA,
  // Device register port.
  output vmon_pkg::dev_bus_s      DEV_BUS,
  input  wire logic [7:0]         DEV_RDATA
);

  localparam int FILT_UNIT = vmon_pkg::FILT_SAMPLES * OSC_PERIOD_CYC;
  localparam int W         = vmon_pkg::TIMER_W;

  generate
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << W) ||
        OSC_PERIOD_CYC < 1 || FILT_UNIT * 8 >= (1 << W))
    begin : g_bad_param
      $error("vmon_host: wait counts do not fit the timer");
    end
  endgenerate

  typedef enum logic [3:0] {
    ST_IDLE, ST_DET_EN, ST_SETTLE, ST_CFG, ST_FLAG, ST_OSC, ST_FWAIT,
    ST_ENABLE, ST_DISABLE, ST_FCLR, ST_RDLVL, ST_RDFLAG
  } seq_e;

  seq_e              st;
  vmon_pkg::cfg_s    cfg_reg;
  vmon_pkg::cfg_s    run_cfg;
  vmon_pkg::status_s status;
  logic [7:0]        det_shadow;
  logic [7:0]        clk_shadow;
  logic [7:0]        one_shadow;
  logic [7:0]        two_shadow;
  logic              one_settled;
  logic              two_settled;
  logic              seq_done;
  logic              refused;
  logic              level_above;
  logic              level_valid;
  logic              cross_flag;
  logic              issued;
  logic              go;
  logic              advance;
  logic              is_access;
  logic              is_wait;
  logic              acc_we;
  logic [7:0]        acc_addr;
  logic [7:0]        acc_wdata;
  logic              acc_done;
  logic [7:0]        acc_rdata;
  logic [W-1:0]      wait_load;
  logic              timer_idle;
  logic              ctrl_wr;
  logic              any_cmd;
  logic              lvl_ok;
  logic [7:0]        mon_shadow;
  logic [W-1:0]      state_cyc;
  logic              flag_cleared;

  // Applies the forced settings of each mode to what software asked for.
  function automatic vmon_pkg::cfg_s effective(input vmon_pkg::cfg_s c);
    vmon_pkg::cfg_s e;
    e = c;
    e.use_filter = c.use_filter & ~c.stop_wake; // [R3] [R4]
    if (!c.mon_two)
      e.mode = 1'b1; // [R10]
    if (!c.mon_two && !e.use_filter)
      e.direction = 1'b1; // [R8]
    if (c.mon_two && c.mode)
      e.direction = 1'b1; // [R12]
    return e;
  endfunction

  // Builds a monitor control byte; divider and direction go in together.
  function automatic logic [7:0] ctrl_byte(input vmon_pkg::cfg_s c,
                                           input logic en);
    logic [7:0] b;
    b = 8'h00;
    b[vmon_pkg::MON_ENABLE_BIT]     = en;
    b[vmon_pkg::MON_FILTER_OFF_BIT] = ~c.use_filter; // [R7] [R9]
    b[vmon_pkg::MON_FCLK_SEL_LO_BIT +: 2] = c.fclk_sel; // [R7]
    b[vmon_pkg::MON_MODE_BIT]       = c.mode; // [R11]
    b[vmon_pkg::MON_DIRECTION_BIT]  = c.direction; // [R20]
    return b;
  endfunction

  assign ctrl_wr = CMD_WR && CMD_ADDR == vmon_pkg::CMD_CTRL_OFS;
  assign any_cmd = ctrl_wr && (CMD_WDATA[6:0] != 7'h00);
  assign lvl_ok  = two_settled; // [R2]
  assign mon_shadow = run_cfg.mon_two ? two_shadow : one_shadow;

  assign is_access = (st != ST_IDLE) && (st != ST_SETTLE)
                     && (st != ST_FWAIT);
  assign is_wait   = (st == ST_SETTLE) || (st == ST_FWAIT);
  assign go        = (is_access || is_wait) && !issued;
  assign advance   = acc_done || (is_wait && issued && timer_idle);
  assign acc_we    = (st != ST_RDLVL) && (st != ST_RDFLAG);

  // Address and data of the device access that the current step makes.
  always_comb
  begin
    acc_addr  = run_cfg.mon_two ? vmon_pkg::MON_TWO_CTRL_ADDR
                                : vmon_pkg::MON_ONE_CTRL_ADDR;
    acc_wdata = 8'h00;
    unique case (st)
      ST_DET_EN:
      begin
        acc_addr  = vmon_pkg::DETECTOR_ENABLE_ADDR;
        acc_wdata = det_shadow;
        if (run_cfg.mon_two)
          acc_wdata[vmon_pkg::DET_TWO_ENABLE_BIT] = 1'b1; // [R6]
        else
          acc_wdata[vmon_pkg::DET_ONE_ENABLE_BIT] = 1'b1; // [R5]
      end
      ST_CFG:
        acc_wdata = ctrl_byte(run_cfg, 1'b0); // [R18]
      ST_FLAG:
        acc_wdata = ctrl_byte(run_cfg, 1'b0); // [R13] [R14]
      ST_OSC:
      begin
        acc_addr  = vmon_pkg::SYS_CLOCK_CTRL_ONE_ADDR;
        acc_wdata = clk_shadow;
        acc_wdata[vmon_pkg::LOWSPEED_OSC_STOP_BIT] = 1'b0; // [R15]
      end
      ST_ENABLE:
        acc_wdata = ctrl_byte(run_cfg, 1'b1); // [R17]
      ST_DISABLE:
      begin
        acc_wdata = mon_shadow;
        acc_wdata[vmon_pkg::MON_ENABLE_BIT] = 1'b0;
      end
      ST_FCLR:
      begin
        acc_wdata = mon_shadow;
        acc_wdata[vmon_pkg::MON_CROSS_FLAG_BIT] = 1'b0; // [R21]
      end
      ST_RDLVL:
        acc_addr = vmon_pkg::LEVEL_STATUS_ADDR; // [R1]
      ST_RDFLAG:
        acc_addr = vmon_pkg::MON_TWO_CTRL_ADDR;
      default:
        acc_wdata = 8'h00;
    endcase
  end

  // Sampling clock is the oscillator divided by 2**sel; four of them.
  assign wait_load = (st == ST_SETTLE) ? W'(SETTLE_CYC) // [R23]
                     : W'(FILT_UNIT) << run_cfg.fclk_sel; // [R16] [R19]

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      issued <= 1'b0;
    else if (advance)
      issued <= 1'b0;
    else if (go)
      issued <= 1'b1;
  end

  // Sequencer.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st      <= ST_IDLE;
      run_cfg <= vmon_pkg::CFG_RST;
    end
    else
    begin
      unique case (st)
        ST_IDLE:
          if (ctrl_wr)
          begin
            run_cfg <= effective(cfg_reg);
            if (CMD_WDATA[vmon_pkg::CTRL_START_BIT])
              st <= (cfg_reg.mon_two ? two_settled : one_settled)
                    ? ST_CFG : ST_DET_EN;
            else if (CMD_WDATA[vmon_pkg::CTRL_DISABLE_BIT])
              st <= ST_DISABLE;
            else if (CMD_WDATA[vmon_pkg::CTRL_CLEAR_FLAG_BIT])
              st <= ST_FCLR;
            else if (CMD_WDATA[vmon_pkg::CTRL_READ_LEVEL_BIT] && lvl_ok)
              st <= ST_RDLVL; // [R2]
            else if (CMD_WDATA[vmon_pkg::CTRL_READ_FLAG_BIT])
              st <= ST_RDFLAG;
          end
        ST_DET_EN:
          if (advance)
            st <= ST_SETTLE;
        ST_SETTLE:
          if (advance)
            st <= ST_CFG; // [R5] [R6]
        ST_CFG:
          if (advance)
            st <= ST_FLAG;
        ST_FLAG:
          if (advance)
            st <= run_cfg.use_filter ? ST_OSC : ST_ENABLE; // [R16]
        ST_OSC:
          if (advance)
            st <= ST_FWAIT;
        ST_FWAIT:
          if (advance)
            st <= ST_ENABLE;
        ST_ENABLE, ST_DISABLE, ST_FCLR, ST_RDLVL, ST_RDFLAG:
          if (advance)
            st <= ST_IDLE;
      endcase
    end
  end

  // Shadows of what was last written to the device.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      det_shadow <= vmon_pkg::DETECTOR_ENABLE_RST;
      clk_shadow <= vmon_pkg::SYS_CLOCK_CTRL_ONE_RST;
      one_shadow <= vmon_pkg::MON_CTRL_RST;
      two_shadow <= vmon_pkg::MON_CTRL_RST;
    end
    else if (acc_done && acc_we)
    begin
      if (st == ST_DET_EN)
        det_shadow <= acc_wdata;
      else if (st == ST_OSC)
        clk_shadow <= acc_wdata;
      else if (run_cfg.mon_two)
        two_shadow <= acc_wdata;
      else
        one_shadow <= acc_wdata;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      one_settled <= 1'b0;
      two_settled <= 1'b0;
    end
    else if (st == ST_SETTLE && advance)
    begin
      if (run_cfg.mon_two)
        two_settled <= 1'b1;
      else
        one_settled <= 1'b1;
    end
  end

  // Values read back from the device.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      level_above <= 1'b0;
      level_valid <= 1'b0;
      cross_flag  <= 1'b0;
    end
    else if (acc_done && st == ST_RDLVL)
    begin
      level_above <= acc_rdata[vmon_pkg::SUPPLY_ABOVE_TWO_BIT];
      level_valid <= 1'b1;
    end
    else if (acc_done && st == ST_RDFLAG)
      cross_flag <= acc_rdata[vmon_pkg::MON_CROSS_FLAG_BIT];
  end

  // A refused command sets the flag even in its clearing cycle.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      refused <= 1'b0;
    else if (any_cmd && (st != ST_IDLE || (!lvl_ok &&
             CMD_WDATA[vmon_pkg::CTRL_READ_LEVEL_BIT] &&
             CMD_WDATA[3:0] == 4'h2)))
      refused <= 1'b1;
    else if (ctrl_wr && CMD_WDATA[vmon_pkg::CTRL_CLR_REFUSED_BIT])
      refused <= 1'b0;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      seq_done <= 1'b0;
    else if (st == ST_ENABLE && advance)
      seq_done <= 1'b1;
    else if (st == ST_IDLE && ctrl_wr &&
             CMD_WDATA[vmon_pkg::CTRL_START_BIT])
      seq_done <= 1'b0;
  end

  // Command registers.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      cfg_reg <= vmon_pkg::CFG_RST;
    else if (CMD_WR && CMD_ADDR == vmon_pkg::CMD_CFG_OFS)
      cfg_reg <= CMD_WDATA[6:0];
  end

  always_comb
  begin
    status             = '0;
    status.busy        = (st != ST_IDLE);
    status.done        = seq_done;
    status.level_above = level_above;
    status.level_valid = level_valid;
    status.one_active  = one_shadow[vmon_pkg::MON_ENABLE_BIT];
    status.two_active  = two_shadow[vmon_pkg::MON_ENABLE_BIT];
    status.cross_flag  = cross_flag;
    status.refused     = refused;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      CMD_RDATA <= 8'h00;
    else if (CMD_RD && CMD_ADDR == vmon_pkg::CMD_CFG_OFS)
      CMD_RDATA <= {1'b0, cfg_reg};
    else if (CMD_RD && CMD_ADDR == vmon_pkg::CMD_STATUS_OFS)
      CMD_RDATA <= status;
    else
      CMD_RDATA <= 8'h00;
  end

  dev_access u_access (
    .clk       (CORE_CLK),
    .rst_b     (RST_B),
    .req       (go && is_access),
    .we        (acc_we),
    .addr      (acc_addr),
    .wdata     (acc_wdata),
    .done      (acc_done),
    .rdata     (acc_rdata),
    .bus       (DEV_BUS),
    .dev_rdata (DEV_RDATA)
  );

  wait_timer #(.W(W)) u_timer (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .start (go && is_wait),
    .load  (wait_load),
    .idle  (timer_idle)
  );

  // Helper state that only the checks below read.
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      state_cyc <= '0;
    else if (advance || st == ST_IDLE)
      state_cyc <= '0;
    else if (state_cyc != '1)
      state_cyc <= state_cyc + W'(1);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
      flag_cleared <= 1'b0;
    else if (st == ST_FLAG && acc_done)
      flag_cleared <= 1'b1;
    else if (st == ST_IDLE)
      flag_cleared <= 1'b0;
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  sequence mon_write_s(logic [7:0] a);
    DEV_BUS.wr && DEV_BUS.addr == a;
  endsequence

  settle_wait_a: assert property ( // [R5] [R6] [R23]
    st == ST_SETTLE && advance |-> state_cyc >= W'(SETTLE_CYC))
    else $error("configuration started before settling delay");

  filter_wait_a: assert property ( // [R16]
    st == ST_FWAIT && advance
    |-> state_cyc >= (W'(FILT_UNIT) << run_cfg.fclk_sel))
    else $error("monitor enabled before four sampling clocks");

  one_reset_mode_a: assert property ( // [R10]
    mon_write_s(vmon_pkg::MON_ONE_CTRL_ADDR)
    |-> DEV_BUS.wdata[vmon_pkg::MON_MODE_BIT])
    else $error("monitor one written outside reset mode");

  two_reset_dir_a: assert property ( // [R12]
    mon_write_s(vmon_pkg::MON_TWO_CTRL_ADDR)
    && DEV_BUS.wdata[vmon_pkg::MON_MODE_BIT]
    |-> DEV_BUS.wdata[vmon_pkg::MON_DIRECTION_BIT])
    else $error("monitor two reset mode without falling direction");

  cfg_disabled_a: assert property ( // [R18]
    st == ST_CFG && acc_done |-> !acc_wdata[vmon_pkg::MON_ENABLE_BIT]
    && $past(DEV_BUS.wdata) == acc_wdata)
    else $error("combined configuration write not disabled");

  osc_before_en_a: assert property ( // [R15]
    $rose(st == ST_ENABLE) && run_cfg.use_filter
    |-> !clk_shadow[vmon_pkg::LOWSPEED_OSC_STOP_BIT])
    else $error("filtered monitor enabled with oscillator stopped");

  flag_before_en_a: assert property ( // [R13] [R14]
    $rose(st == ST_ENABLE) |-> flag_cleared)
    else $error("monitor enabled without clearing its flag");

  stop_wake_a: assert property ( // [R3] [R4]
    st == ST_CFG && run_cfg.stop_wake && go
    ##1 (st == ST_CFG) [*1]
    |-> acc_wdata[vmon_pkg::MON_FILTER_OFF_BIT])
    else $error("stop wake configured with filter in use");

  level_gate_a: assert property ( // [R2]
    $rose(st == ST_RDLVL) |-> two_settled)
    else $error("level read before detector two settled");

  enable_last_a: assert property ( // [R17]
    st == ST_ENABLE && acc_done |=> st == ST_IDLE && seq_done)
    else $error("setup did not finish on enable write");

endmodule // vmon_host

// [vmon_dev_model.sv]
`timescale 1ns/1ps
module vmon_dev_model #(
  parameter int SETTLE = 4,
  parameter int OSC    = 2
) (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Register port and supply.
  input  wire vmon_pkg::dev_bus_s bus,
  input  wire logic               above,
  output logic [7:0]              rdata,
  output logic [7:0]              viol
);
  logic [7:0] r [0:7];
  logic       unlk;
  int         age;
  int         oage;
  logic [7:0] v;
  logic [2:0] a;
  logic [7:0] d;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      r <= '{default: 8'h00};
      unlk <= 1'b0;
      age <= 0;
      oage <= 0;
      viol <= 8'h00;
      rdata <= 8'h00;
    end
    else
    begin
      v = viol;
      a = bus.addr[2:0];
      d = bus.wdata;
      age <= age + 1;
      oage <= oage + 1;
      // A released bus toggles so a late sample never looks valid.
      rdata <= ~rdata;
      if (bus.rd)
        rdata <= (a == 3'h2) ? {4'h0, ~r[3][7] | above, 3'h0} : r[a];
      if (bus.rd && a == 3'h2 && age < SETTLE)
        v = v + 8'h01;
      // An enabled monitor two below its threshold raises its flag.
      if (r[5][0] && !above)
        r[5][2] <= 1'b1;
      if (bus.wr)
      begin
        unlk <= (a == 3'h0) && d[3];
        if (a != 3'h0 && !unlk)
          v = v + 8'h01;
        else if (a == 3'h4 || a == 3'h5)
        begin
          if (!r[3][a + 3'h2] || age < SETTLE)
            v = v + 8'h01;
          if (d[0] && !r[a][0] && (d[2] || r[a][2]))
            v = v + 8'h01;
          if (d[0] && !r[a][0] && !d[1]
              && (r[1][4] || oage < 4 * OSC * (1 << d[5:4])))
            v = v + 8'h01;
          if (a == 3'h4 && d[0] && !d[6])
            v = v + 8'h01;
          if (a == 3'h5 && d[6] && !d[7])
            v = v + 8'h01;
          r[a] <= {d[7:3], d[2] & r[a][2], d[1:0]};
        end
        else
        begin
          if (a == 3'h3 && ((d[7] && !r[3][7]) || (d[6] && !r[3][6])))
            age <= 0;
          if (a == 3'h1 && !d[4])
            oage <= 0;
          r[a] <= d;
        end
      end
      viol <= v;
    end
endmodule // vmon_dev_model

// [supply_monitor_reset_irq_setup_test.sv]
`timescale 1ns/1ps
module supply_monitor_reset_irq_setup_test;
  logic               CORE_CLK  = 1'b0;
  logic               RST_B     = 1'b0;
  logic               CMD_WR    = 1'b0;
  logic               CMD_RD    = 1'b0;
  logic               above     = 1'b1;
  logic [3:0]         CMD_ADDR  = 4'h0;
  logic [7:0]         CMD_WDATA = 8'h00;
  logic [7:0]         CMD_RDATA;
  logic [7:0]         DEV_RDATA;
  logic [7:0]         viol;
  logic [7:0]         d;
  vmon_pkg::dev_bus_s DEV_BUS;
  int                 n_mismatch = 0;
  int                 compares   = 0;
  int                 cyc        = 0;
  logic [7:0]         cfgs [2]   = '{8'h05, 8'h53};
  logic [7:0]         exps [2]   = '{8'hC3, 8'h13};

  vmon_host #(.SETTLE_CYC(4), .OSC_PERIOD_CYC(2)) dut (
    .CORE_CLK (CORE_CLK), .RST_B (RST_B), .CMD_ADDR (CMD_ADDR),
    .CMD_WDATA (CMD_WDATA), .CMD_WR (CMD_WR), .CMD_RD (CMD_RD),
    .CMD_RDATA (CMD_RDATA), .DEV_BUS (DEV_BUS), .DEV_RDATA (DEV_RDATA));
  vmon_dev_model #(.SETTLE(4), .OSC(2)) dev (
    .clk (CORE_CLK), .rst_b (RST_B), .bus (DEV_BUS), .above (above),
    .rdata (DEV_RDATA), .viol (viol));

  initial
  begin
    forever #25 CORE_CLK = ~CORE_CLK;
  end

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge CORE_CLK)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CORE_CLK);
    CMD_WR <= 1'b1;
    CMD_ADDR <= a;
    CMD_WDATA <= v;
    @(posedge CORE_CLK);
    CMD_WR <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge CORE_CLK);
    CMD_RD <= 1'b1;
    CMD_ADDR <= a;
    @(posedge CORE_CLK);
    CMD_RD <= 1'b0;
    #1 d = CMD_RDATA;
  endtask

  // Polls busy under a bound; the device waits here are 4 cycles to settle and 16 for the filter.
  task automatic run(input logic [7:0] ctl);
    wr(4'h1, ctl);
    for (int i = 0; i < 3000; i++)
    begin
      rd(4'h2);
      if (d[0] === 1'b0)
        break;
    end
    chk(d & 8'h01, 8'h00);
  endtask

  task automatic s_reset;
    rd(4'h2);
    chk(d, 8'h00);
    rd(4'hF);
    chk(d, 8'h00);
    // A level read before detector two has settled is refused.
    wr(4'h1, 8'h02);
    rd(4'h2);
    chk(d, 8'h80);
    wr(4'h1, 8'h80);
  endtask

  task automatic s_two_filter;
    wr(4'h0, 8'h93);
    rd(4'h0);
    chk(d, 8'h13);
    wr(4'h1, 8'h01);
    run(8'h01);
    chk(d & 8'hB3, 8'hA2);
    chk(dev.r[5], 8'h11);
    wr(4'h1, 8'h80);
    rd(4'h2);
    chk(d[7], 1'b0);
  endtask

  task automatic s_level;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge CORE_CLK);
      above <= i[0];
      run(8'h02);
      chk(d & 8'h0C, {4'h0, 1'b1, i[0], 2'b00});
    end
  endtask

  task automatic s_mon_one;
    // Stop wake must override the requested filter.
    wr(4'h0, 8'h42);
    run(8'h01);
    chk(dev.r[4], 8'hC3);
    chk(d[4], 1'b1);
  endtask

  task automatic s_two_modes;
    for (int i = 0; i < 2; i++)
    begin
      wr(4'h0, cfgs[i]);
      run(8'h08);
      chk(dev.r[5][0], 1'b0);
      run(8'h01);
      chk(dev.r[5], exps[i]);
    end
    above <= 1'b0;
    run(8'h10);
    chk(d[6], 1'b1);
    above <= 1'b1;
    run(8'h04);
    run(8'h10);
    chk(d[6], 1'b0);
  endtask

  initial
  begin
    repeat (4) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    s_reset();
    s_two_filter();
    s_level();
    s_mon_one();
    s_two_modes();
    chk(viol, 8'h00);
    end_of_test();
  end
endmodule // supply_monitor_reset_irq_setup_test
